// ===== src/ism_top.sv
// ism_top: interrupt enable mask and interrupt pin driver
// assumes: fault detectors and the serial decoder run on clock
`timescale 1ns/1ps
//
// Contract
// - CAN interface faults reach the interrupt pin only while mask bit 7 is 1.
// - Setting the software request bit together with safety bit 2 gives one single interrupt event.
// - Second LIN channel faults reach the pin only while mask bit 5 is 1.
// - First LIN channel faults reach the pin only while mask bit 4 is 1.
// - I/O pin faults reach the pin only while mask bit 3 is 1.
// - Safety faults reach the pin only while mask bit 2 is 1.
// - Regulator monitor faults reach the pin only while mask bit 0 is 1.
// - The software request fires only when bits 6 and 2 are written as 1.
// - Core undervoltage counts as a safety fault only at the 70% threshold.
// - In full identification mode a CAN fault fires after five tx pulses.
module ism_top
  import ism_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  // decoded register write
  input  wire logic       reg_wr,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  // CAN fault detection
  input  wire logic       can_fault_det,
  input  wire logic       can_tx_dom_pulse,
  input  wire logic       can_report_early,
  // LIN and I/O fault events
  input  wire logic       lin_chan1_fault_evt,
  input  wire logic       lin_chan2_fault_evt,
  input  wire logic       io_fault_evt,
  // safety group events
  input  wire logic       vaux_ov_evt,
  input  wire logic       vdd_ov_evt,
  input  wire logic       vdd_temp_warn_evt,
  input  wire logic       vdd_uv_evt,
  input  wire logic       uv_thresh_70,
  input  wire logic       safe_res_mismatch_evt,
  input  wire logic       rst_short_vdd_evt,
  // regulator monitor events
  input  wire logic       vmon_fault_evt,
  // mask readback and interrupt pin
  output logic [7:0]      mask_out,
  output logic            int_n
);

  typedef struct packed {
    logic [7:0] mask;
    logic       can_det_d;
    logic [2:0] can_cnt;
    logic       can_armed;
    logic       int_n;
  } ism_state_t;

  ism_state_t state_reg;
  ism_state_t state_next;

  logic mask_wr;
  logic sw_req;
  logic can_evt;
  logic safe_evt;
  logic irq_any;

  //////////////////////////////////////////////////////////////////////////
  // event qualification
  always_comb begin
    mask_wr  = reg_wr && (reg_addr == ISM_MASK_ADDR);
    // fire on the write that makes both bits set, not while they stay set
    sw_req   = mask_wr && reg_wdata[ISM_B_SWREQ] && reg_wdata[ISM_B_SAFE]
               && !(state_reg.mask[ISM_B_SWREQ]
                    && state_reg.mask[ISM_B_SAFE]);
    safe_evt = vaux_ov_evt || vdd_ov_evt || vdd_temp_warn_evt
               || (vdd_uv_evt && uv_thresh_70)
               || safe_res_mismatch_evt || rst_short_vdd_evt;
    if (can_report_early) begin
      can_evt = can_fault_det && !state_reg.can_det_d;
    end else begin
      can_evt = state_reg.can_armed && can_tx_dom_pulse
                && (state_reg.can_cnt == ISM_CAN_DECODE_N - ISM_CNT_ONE);
    end
    irq_any = (can_evt && state_reg.mask[ISM_B_CAN])
           || sw_req
           || (lin_chan2_fault_evt && state_reg.mask[ISM_B_LIN2])
           || (lin_chan1_fault_evt && state_reg.mask[ISM_B_LIN1])
           || (io_fault_evt && state_reg.mask[ISM_B_IO])
           || (safe_evt && state_reg.mask[ISM_B_SAFE])
           || (vmon_fault_evt && state_reg.mask[ISM_B_VMON]);
    // next state
    state_next           = state_reg;
    state_next.can_det_d = can_fault_det;
    if (mask_wr) begin
      state_next.mask = reg_wdata;
    end
    // count dominant pulses while a fault is detected, stop once decoded
    if (!can_fault_det) begin
      state_next.can_cnt   = ISM_CNT_ZERO;
      state_next.can_armed = 1'b0;
    end else if (!state_reg.can_det_d) begin
      state_next.can_cnt   = can_tx_dom_pulse ? ISM_CNT_ONE : ISM_CNT_ZERO;
      state_next.can_armed = 1'b1;
    end else if (state_reg.can_armed && can_tx_dom_pulse) begin
      if (state_reg.can_cnt == ISM_CAN_DECODE_N - ISM_CNT_ONE) begin
        state_next.can_armed = 1'b0;
      end else begin
        state_next.can_cnt = state_reg.can_cnt + ISM_CNT_ONE;
      end
    end
    state_next.int_n = !irq_any;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg.mask      <= ISM_MASK_RESET;
      state_reg.can_det_d <= 1'b0;
      state_reg.can_cnt   <= ISM_CNT_ZERO;
      state_reg.can_armed <= 1'b0;
      state_reg.int_n     <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign mask_out = state_reg.mask;
  assign int_n    = state_reg.int_n;

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fresh_req;
    ce && reg_wr && reg_addr == ISM_MASK_ADDR
    && reg_wdata[ISM_B_SWREQ] && reg_wdata[ISM_B_SAFE]
    && !(mask_out[ISM_B_SWREQ] && mask_out[ISM_B_SAFE]);
  endsequence

  property p_sw_req_once;
    @(posedge clock) disable iff (rst)
    s_fresh_req |=> !int_n;
  endproperty
  a_sw_req_once: assert property (p_sw_req_once)
    else $error("software request gave no interrupt");

  property p_sw_req_pair;
    @(posedge clock) disable iff (rst)
    (ce && mask_out == ISM_MASK_RESET && reg_wr
     && reg_addr == ISM_MASK_ADDR && !reg_wdata[ISM_B_SAFE])
    |=> int_n;
  endproperty
  a_sw_req_pair: assert property (p_sw_req_pair)
    else $error("request fired without safety bit");

  property p_lin2;
    @(posedge clock) disable iff (rst)
    ce && lin_chan2_fault_evt && mask_out[ISM_B_LIN2] |=> !int_n;
  endproperty
  a_lin2: assert property (p_lin2)
    else $error("lin channel 2 fault lost");

  property p_lin1;
    @(posedge clock) disable iff (rst)
    ce && lin_chan1_fault_evt && mask_out[ISM_B_LIN1] |=> !int_n;
  endproperty
  a_lin1: assert property (p_lin1)
    else $error("lin channel 1 fault lost");

  property p_io;
    @(posedge clock) disable iff (rst)
    ce && io_fault_evt && mask_out[ISM_B_IO] |=> !int_n;
  endproperty
  a_io: assert property (p_io)
    else $error("io fault lost");

  property p_uv70;
    @(posedge clock) disable iff (rst)
    ce && vdd_uv_evt && uv_thresh_70 && mask_out[ISM_B_SAFE] |=> !int_n;
  endproperty
  a_uv70: assert property (p_uv70)
    else $error("core undervoltage fault lost");

  property p_vmon;
    @(posedge clock) disable iff (rst)
    ce && vmon_fault_evt && mask_out[ISM_B_VMON] |=> !int_n;
  endproperty
  a_vmon: assert property (p_vmon)
    else $error("regulator monitor fault lost");

  property p_can_decoded;
    @(posedge clock) disable iff (rst)
    ce && !can_report_early && can_fault_det && can_tx_dom_pulse
    && state_reg.can_armed && mask_out[ISM_B_CAN]
    && state_reg.can_cnt == ISM_CAN_DECODE_N - ISM_CNT_ONE |=> !int_n;
  endproperty
  a_can_decoded: assert property (p_can_decoded)
    else $error("decoded can fault lost");

  property p_masked_quiet;
    @(posedge clock) disable iff (rst)
    ce && mask_out == ISM_MASK_RESET
    && !(reg_wr && reg_addr == ISM_MASK_ADDR) |=> int_n;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt with all groups masked");

  property p_mask_write;
    @(posedge clock) disable iff (rst)
    ce && reg_wr && reg_addr == ISM_MASK_ADDR |=> mask_out == $past(reg_wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not taken");

  // rewriting a request that is already stored must stay quiet
  property p_sw_req_no_refire;
    @(posedge clock) disable iff (rst)
    ce && reg_wr && reg_addr == ISM_MASK_ADDR
    && reg_wdata == mask_out && mask_out[ISM_B_SWREQ]
    && mask_out[ISM_B_SAFE] && !mask_out[ISM_B_CAN]
    && !mask_out[ISM_B_LIN2] && !mask_out[ISM_B_LIN1]
    && !mask_out[ISM_B_IO] && !mask_out[ISM_B_VMON] && !safe_evt
    |=> int_n;
  endproperty
  a_sw_req_no_refire: assert property (p_sw_req_no_refire)
    else $error("software request fired twice");

  property p_ce_hold;
    @(posedge clock) disable iff (rst)
    !ce |=> $stable(mask_out) && $stable(int_n);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("state moved while clock enable low");

endmodule

// ===== src/ism_pkg.sv
// ism_pkg: constants for the interrupt source mask block
// assumes: register writes arrive already decoded from the serial frame
package ism_pkg;
  // register address field of the serial frame
  localparam logic [4:0] ISM_MASK_ADDR    = 5'h12;
  localparam logic [7:0] ISM_MASK_RESET   = 8'h00;
  // mask bit positions
  localparam int         ISM_B_CAN        = 7;
  localparam int         ISM_B_SWREQ      = 6;
  localparam int         ISM_B_LIN2       = 5;
  localparam int         ISM_B_LIN1       = 4;
  localparam int         ISM_B_IO         = 3;
  localparam int         ISM_B_SAFE       = 2;
  localparam int         ISM_B_VMON       = 0;
  // dominant transmit pulses needed to decode a bus fault
  localparam logic [2:0] ISM_CAN_DECODE_N = 3'h5;
  localparam logic [2:0] ISM_CNT_ZERO     = 3'h0;
  localparam logic [2:0] ISM_CNT_ONE      = 3'h1;
endpackage

// ===== verification/ism_host.sv
// ism_host: host side model issuing decoded mask register writes
// assumes: writes are taken on rising clock edges
`timescale 1ns/1ps
module ism_host
  import ism_pkg::*;
(
  // clock
  input  wire logic       clock,
  // decoded register write
  output logic            reg_wr,
  output logic [4:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write; released fields show inverted values, not stale ones
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  // software request needs both request and safety bits written as 1
  task automatic sw_request(input logic [7:0] m);
    wr(ISM_MASK_ADDR, m | 8'h44);
  endtask
endmodule

// ===== verification/ism_top_test.sv
// ism_top_test: directed checks of mask writes and interrupt gating
// assumes: ism_host drives the register write port
`timescale 1ns/1ps
module ism_top_test;
  import ism_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic [9:0] ev = 10'h000;
  logic       det = 1'b0;
  logic       tx = 1'b0;
  logic       early = 1'b0;
  logic       uv70 = 1'b1;
  logic       reg_wr;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] mask_out;
  logic       int_n;
  int         num_errors = 0;
  int         total_checks = 0;
  always #5 clock = ~clock;
  ism_host host (.clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  ism_top dut (.clock(clock), .rst(rst), .ce(ce), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .can_fault_det(det),
    .can_tx_dom_pulse(tx), .can_report_early(early),
    .lin_chan1_fault_evt(ev[0]), .lin_chan2_fault_evt(ev[1]),
    .io_fault_evt(ev[2]), .vaux_ov_evt(ev[3]), .vdd_ov_evt(ev[4]),
    .vdd_temp_warn_evt(ev[5]), .vdd_uv_evt(ev[6]), .uv_thresh_70(uv70),
    .safe_res_mismatch_evt(ev[7]), .rst_short_vdd_evt(ev[8]),
    .vmon_fault_evt(ev[9]), .mask_out(mask_out), .int_n(int_n));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // count cycles with the pin low over the next n cycles
  task automatic lows(input int n, input logic [7:0] e, input string nm);
    logic [7:0] c;
    c = 8'h00;
    repeat (n) begin
      @(negedge clock);
      if (int_n !== 1'b1) c++;
    end
    chk(nm, e, c);
  endtask
  task automatic fire(input int i, input logic [7:0] e);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
    lows(3, e, "event irq");
  endtask
  task automatic txp;
    @(posedge clock);
    det <= 1'b1;
    tx  <= 1'b1;
    @(posedge clock);
    tx  <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reg;
    chk("mask reset", ISM_MASK_RESET, mask_out);
    chk("int reset", 8'h01, {7'h00, int_n});
    host.wr(ISM_MASK_ADDR, 8'hA9);
    host.wr(5'h13, 8'h10);
    @(negedge clock);
    chk("mask", 8'hA9, mask_out);
    $display("test reg done");
  endtask
  task automatic t_groups;
    int b [10] = '{4, 5, 3, 2, 2, 2, 2, 2, 2, 0};
    for (int i = 0; i < 10; i++) begin
      host.wr(ISM_MASK_ADDR, 8'h01 << b[i]);
      fire(i, 8'h01);
      host.wr(ISM_MASK_ADDR, ~(8'h01 << b[i]) & 8'hBF);
      fire(i, 8'h00);
    end
    $display("test groups done");
  endtask
  task automatic t_swreq;
    host.wr(ISM_MASK_ADDR, 8'h40);
    lows(3, 8'h00, "req no safe");
    host.sw_request(8'h00);
    lows(3, 8'h01, "req");
    host.sw_request(8'h00);
    lows(3, 8'h00, "req rewrite");
    @(posedge clock);
    uv70 <= 1'b0;
    fire(6, 8'h00);
    @(posedge clock);
    uv70 <= 1'b1;
    fire(6, 8'h01);
    $display("test swreq done");
  endtask
  task automatic t_can;
    host.wr(ISM_MASK_ADDR, 8'h80);
    repeat (4) txp;
    lows(3, 8'h00, "can 4 pulses");
    txp;
    lows(3, 8'h01, "can 5 pulses");
    @(posedge clock);
    det   <= 1'b0;
    early <= 1'b1;
    @(posedge clock);
    det <= 1'b1;
    lows(3, 8'h01, "can early");
    host.wr(ISM_MASK_ADDR, 8'h00);
    @(posedge clock);
    det <= 1'b0;
    @(posedge clock);
    det <= 1'b1;
    lows(3, 8'h00, "can masked");
    $display("test can done");
  endtask
  // clock enable low must freeze the mask and the pin
  task automatic t_hold;
    host.wr(ISM_MASK_ADDR, 8'h10);
    ce <= 1'b0;
    fire(0, 8'h00);
    host.wr(ISM_MASK_ADDR, 8'h00);
    ce <= 1'b1;
    @(negedge clock);
    chk("mask frozen", 8'h10, mask_out);
    fire(0, 8'h01);
    $display("test hold done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    t_reg;
    t_groups;
    t_swreq;
    t_can;
    t_hold;
    results;
  end
  initial begin
    #100000;
    num_errors++;
    results;
  end
endmodule
